// *** src/etc_pkg.sv ***
package etc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ETC_ADDR_KIND_CONFIG = 8'h08;
  localparam int ETC_NUM_EP = 16;
  localparam int ETC_IDX_W = 4;
  localparam logic [15:0] ETC_KIND_RESET = 16'h0000;
  localparam logic [15:0] ETC_DEFINED_MASK = 16'h001f;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ETC_BIT_SUPPRESS = 4;
  localparam int ETC_BIT_ENABLE = 3;
  localparam int ETC_BIT_DUAL = 2;
  localparam int ETC_BIT_KIND_HI = 1;
  localparam int ETC_BIT_KIND_LO = 0;
  // ----------------------------------------
  // Transfer kinds
  // ----------------------------------------
  typedef enum logic [1:0] {
    ETC_KIND_UNUSED = 2'h0,
    ETC_KIND_ISO = 2'h1,
    ETC_KIND_BULK = 2'h2,
    ETC_KIND_INTR = 2'h3
  } etc_kind_e;
  // ----------------------------------------
  // Per-endpoint configuration
  // ----------------------------------------
  typedef struct packed {
    logic zero_len_pkt_suppress;
    logic ep_enable;
    logic dual_buffer_en;
    etc_kind_e transfer_kind_sel;
  } etc_cfg_s;
  // ----------------------------------------
  // Register port bundle
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } etc_req_s;
  // ----------------------------------------
  // Endpoint status bundle
  // ----------------------------------------
  typedef struct packed {
    logic fifo_active;
    logic dual_buffer_en;
    logic buf_sel;
    logic data_toggle;
    logic zlp_pending;
    logic is_iso;
    logic is_bulk;
    logic is_intr;
  } etc_stat_s;
endpackage

// *** src/etc_ep_state.sv ***
`timescale 1ns/1ps
// Per-endpoint toggle, buffer pointer and zero-length packet state
module etc_ep_state
  import etc_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_bus_reset,
  // Configuration
  input wire etc_cfg_s i_cfg,
  input wire logic i_enable_rise,
  // Traffic events
  input wire logic i_pkt_done,
  input wire logic i_dma_in_done,
  input wire logic i_in_token,
  // State
  output logic o_toggle,
  output logic o_buf_sel,
  output logic o_zlp_pending
);
  logic toggle_ff;
  logic buf_sel_ff;
  logic zlp_ff;
  logic active;

  assign active = i_cfg.ep_enable;
  assign o_toggle = toggle_ff;
  assign o_buf_sel = buf_sel_ff;
  assign o_zlp_pending = zlp_ff;

  // ----------------------------------------
  // Data toggle
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      toggle_ff <= 1'b0;
    else if (i_bus_reset || i_enable_rise)
      toggle_ff <= 1'b0; // [R9]
    else if (active && i_pkt_done)
      toggle_ff <= ~toggle_ff; // [R8]
  end

  // ----------------------------------------
  // Buffer pointer
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      buf_sel_ff <= 1'b0;
    else if (i_bus_reset || !active || !i_cfg.dual_buffer_en)
      buf_sel_ff <= 1'b0; // [R10]
    else if (i_pkt_done)
      buf_sel_ff <= ~buf_sel_ff; // [R10]
  end

  // ----------------------------------------
  // Zero-length packet after DMA IN
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      zlp_ff <= 1'b0;
    else if (i_bus_reset || !active)
      zlp_ff <= 1'b0;
    else if (i_dma_in_done && !i_cfg.zero_len_pkt_suppress)
      zlp_ff <= 1'b1; // [R4]
    else if (i_in_token || i_cfg.zero_len_pkt_suppress)
      zlp_ff <= 1'b0; // [R5]
  end
endmodule

// *** src/etc_endpoint_type_config.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// [R1] The kind configuration register sits at offset 08h and acts on the indexed endpoint.
// [R2] The register is 16 bits wide with bits 15 to 5 reserved and five low defined bits.
// [R3] Transfer kind 00 is unused, 01 isochronous, 10 bulk and 11 interrupt.
// [R4] With suppression clear, a zero-length packet answers the next IN after DMA IN ends.
// [R5] With suppression set, no zero-length packet follows a DMA IN completion.
// [R6] Setting the enable bit activates the endpoint FIFO sized by its packet-size register.
// [R7] Clearing the enable bit deactivates the endpoint FIFO.
// [R8] A stall does not reset the data toggle; it resumes where it stood.
// [R9] Disabling then enabling an endpoint resets its toggle; software does this after a stall.
// [R10] Dual buffer set gives two alternating buffers; clear gives one buffer.
// [R11] Software starts a generic DMA transfer by writing an opcode to the DMA command register.
// [R12] Software keeps the sum of enabled endpoint buffers within 8192 bytes.
// [R13] Defined fields clear to zero on device reset and on USB bus reset.
module etc_endpoint_type_config
  import etc_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_bus_reset,
  // Register port
  input wire etc_req_s i_req,
  input wire logic [ETC_IDX_W-1:0] i_ep_index,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  // Endpoint traffic
  input wire logic [ETC_IDX_W-1:0] i_traffic_ep,
  input wire logic i_pkt_done,
  input wire logic i_dma_in_done,
  input wire logic i_in_token,
  input wire logic [10:0] i_fifo_byte_size,
  // Indexed endpoint state and FIFO activity of all endpoints
  output etc_stat_s o_stat,
  output logic [ETC_NUM_EP-1:0] o_fifo_active,
  output logic [11:0] o_alloc_bytes
);
  etc_cfg_s cfg_ff [ETC_NUM_EP];
  logic enable_rise [ETC_NUM_EP];
  logic toggle [ETC_NUM_EP];
  logic buf_sel [ETC_NUM_EP];
  logic zlp [ETC_NUM_EP];
  logic wr_hit;
  logic rd_hit;
  logic pkt_hit [ETC_NUM_EP];
  logic dma_hit [ETC_NUM_EP];
  logic tok_hit [ETC_NUM_EP];
  logic [15:0] rdata_ff;
  logic rvalid_ff;
  etc_stat_s stat_ff;
  logic [ETC_NUM_EP-1:0] fifo_active_ff;
  logic [11:0] alloc_ff;
  etc_cfg_s sel_cfg;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic etc_cfg_s etc_pack_cfg(input logic [15:0] w);
    etc_cfg_s c;
    c.zero_len_pkt_suppress = w[ETC_BIT_SUPPRESS];
    c.ep_enable = w[ETC_BIT_ENABLE];
    c.dual_buffer_en = w[ETC_BIT_DUAL];
    c.transfer_kind_sel = etc_kind_e'(w[ETC_BIT_KIND_HI:ETC_BIT_KIND_LO]);
    return c;
  endfunction

  function automatic logic [15:0] etc_unpack_cfg(input etc_cfg_s c);
    logic [15:0] w;
    w = ETC_KIND_RESET;
    w[ETC_BIT_SUPPRESS] = c.zero_len_pkt_suppress;
    w[ETC_BIT_ENABLE] = c.ep_enable;
    w[ETC_BIT_DUAL] = c.dual_buffer_en;
    w[ETC_BIT_KIND_HI:ETC_BIT_KIND_LO] = c.transfer_kind_sel;
    return w & ETC_DEFINED_MASK;
  endfunction

  function automatic logic etc_addr_hit(input logic [7:0] a);
    return a == ETC_ADDR_KIND_CONFIG;
  endfunction

  function automatic logic etc_ep_match(input logic [ETC_IDX_W-1:0] sel, input int n);
    return sel == ETC_IDX_W'(n);
  endfunction

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  assign wr_hit = i_req.wr && etc_addr_hit(i_req.addr); // [R1]
  assign rd_hit = i_req.rd && etc_addr_hit(i_req.addr); // [R1]
  assign sel_cfg = cfg_ff[i_ep_index];

  // ----------------------------------------
  // Traffic steering
  // ----------------------------------------
  always_comb
  begin
    for (int i = 0; i < ETC_NUM_EP; i++)
    begin
      pkt_hit[i] = i_pkt_done && etc_ep_match(i_traffic_ep, i);
      dma_hit[i] = i_dma_in_done && etc_ep_match(i_traffic_ep, i);
      tok_hit[i] = i_in_token && etc_ep_match(i_traffic_ep, i);
    end
  end

  // ----------------------------------------
  // Configuration storage
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < ETC_NUM_EP; i++)
        cfg_ff[i] <= etc_pack_cfg(ETC_KIND_RESET); // [R13]
    end
    else if (i_bus_reset)
    begin
      for (int i = 0; i < ETC_NUM_EP; i++)
        cfg_ff[i] <= etc_pack_cfg(ETC_KIND_RESET); // [R13]
    end
    else if (wr_hit)
      cfg_ff[i_ep_index] <= etc_pack_cfg(i_req.wdata & ETC_DEFINED_MASK); // [R2]
  end

  // ----------------------------------------
  // Enable edge detection
  // ----------------------------------------
  always_comb
  begin
    for (int i = 0; i < ETC_NUM_EP; i++)
      enable_rise[i] = wr_hit && etc_ep_match(i_ep_index, i) && !cfg_ff[i].ep_enable
        && i_req.wdata[ETC_BIT_ENABLE]; // [R9]
  end

  // ----------------------------------------
  // Per-endpoint state
  // ----------------------------------------
  for (genvar g = 0; g < ETC_NUM_EP; g++)
  begin : g_ep
    etc_ep_state u_state (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_bus_reset(i_bus_reset),
      .i_cfg(cfg_ff[g]),
      .i_enable_rise(enable_rise[g]),
      .i_pkt_done(pkt_hit[g]),
      .i_dma_in_done(dma_hit[g]),
      .i_in_token(tok_hit[g]),
      .o_toggle(toggle[g]),
      .o_buf_sel(buf_sel[g]),
      .o_zlp_pending(zlp[g])
    );
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_ff <= ETC_KIND_RESET;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= i_req.rd;
      if (rd_hit)
        rdata_ff <= etc_unpack_cfg(sel_cfg); // [R2]
      else
        rdata_ff <= ETC_KIND_RESET;
    end
  end

  // ----------------------------------------
  // Indexed endpoint status
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      stat_ff <= '0;
    else
    begin
      stat_ff.fifo_active <= sel_cfg.ep_enable; // [R6]
      stat_ff.dual_buffer_en <= sel_cfg.dual_buffer_en; // [R10]
      stat_ff.buf_sel <= buf_sel[i_ep_index];
      stat_ff.data_toggle <= toggle[i_ep_index];
      stat_ff.zlp_pending <= zlp[i_ep_index];
      stat_ff.is_iso <= sel_cfg.transfer_kind_sel == ETC_KIND_ISO; // [R3]
      stat_ff.is_bulk <= sel_cfg.transfer_kind_sel == ETC_KIND_BULK; // [R3]
      stat_ff.is_intr <= sel_cfg.transfer_kind_sel == ETC_KIND_INTR; // [R3]
    end
  end

  // ----------------------------------------
  // FIFO activation and allocation
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fifo_active_ff <= '0;
      alloc_ff <= '0;
    end
    else
    begin
      for (int i = 0; i < ETC_NUM_EP; i++)
        fifo_active_ff[i] <= cfg_ff[i].ep_enable; // [R7]
      if (!sel_cfg.ep_enable)
        alloc_ff <= '0; // [R7]
      else if (sel_cfg.dual_buffer_en)
        alloc_ff <= {i_fifo_byte_size, 1'b0}; // [R10]
      else
        alloc_ff <= {1'b0, i_fifo_byte_size}; // [R6]
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_rdata = rdata_ff;
  assign o_rvalid = rvalid_ff;
  assign o_stat = stat_ff;
  assign o_fifo_active = fifo_active_ff;
  assign o_alloc_bytes = alloc_ff;
endmodule

// *** bench/etc_checker_asserts.sv ***
`timescale 1ns/1ps
module etc_checker_asserts
  import etc_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_bus_reset,
  // Register port
  input wire etc_req_s i_req,
  input wire logic [ETC_IDX_W-1:0] i_ep_index,
  input wire logic [15:0] o_rdata,
  input wire logic o_rvalid,
  // Status
  input wire etc_stat_s o_stat,
  input wire logic [ETC_NUM_EP-1:0] o_fifo_active,
  input wire logic [11:0] o_alloc_bytes
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_rd_answer: assert property (i_req.rd |=> o_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (o_rvalid |-> $past(i_req.rd))
    else $error("read answer without read");
  a_rsvd_zero: assert property (o_rvalid |-> o_rdata[15:5] == 11'h000)
    else $error("reserved bits not zero");
  a_other_addr: assert property (
    i_req.rd && i_req.addr != ETC_ADDR_KIND_CONFIG |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_kind_onehot: assert property ($onehot0({o_stat.is_iso, o_stat.is_bulk, o_stat.is_intr}))
    else $error("kind decode not exclusive");
  a_enable_write: assert property (
    (i_req.wr && i_req.addr == ETC_ADDR_KIND_CONFIG && !i_bus_reset
    ##1 !i_req.wr && !i_bus_reset) |=>
    o_fifo_active[$past(i_ep_index, 2)] == $past(i_req.wdata[3], 2))
    else $error("fifo enable mismatch");
  a_bus_clear: assert property ((i_bus_reset ##1 !i_req.wr) |=> o_fifo_active == '0)
    else $error("bus reset left endpoint enabled");
  a_alloc_off: assert property (!o_stat.fifo_active |-> o_alloc_bytes == 12'h000)
    else $error("allocation on disabled endpoint");
  cover property (o_rvalid && o_rdata != 16'h0000);
  cover property (o_stat.zlp_pending);
  cover property (o_stat.buf_sel && o_stat.dual_buffer_en);
endmodule
bind etc_endpoint_type_config etc_checker_asserts i_etc_checker_asserts (.*);

// *** bench/etc_host_model.sv ***
`timescale 1ns/1ps
module etc_host_model
  import etc_pkg::*;
(
  // Clock
  input wire logic i_sys_clk,
  // Register requests
  output etc_req_s o_req
);
  // Never issues a DMA command nor enables more than 8192 bytes
  initial o_req = '0;
  // Disable then re-enable after a stall is issued as two writes
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_sys_clk) o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_sys_clk) o_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk) o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge i_sys_clk) o_req <= '0;
  endtask
endmodule

// *** bench/test_endpoint_type_config.sv ***
`timescale 1ns/1ps
module test_endpoint_type_config
  import etc_pkg::*;
;
  logic i_sys_clk = 0;
  logic i_rst_n = 0;
  logic i_bus_reset = 0;
  logic pkt = 0;
  logic dma = 0;
  logic tok = 0;
  logic [3:0] idx = 0;
  logic [3:0] tep = 0;
  logic [10:0] sz = 11'h040;
  etc_req_s req;
  logic [15:0] o_rdata;
  logic o_rvalid;
  etc_stat_s o_stat;
  logic [11:0] alloc;
  logic [15:0] fact;
  logic [15:0] en_exp = '0;
  int error_cnt = 0;
  int n_checks = 0;
  logic [15:0] expq[$];
  logic [31:0] rs = 42;
  always #12.5 i_sys_clk = ~i_sys_clk;
  etc_host_model i_etc_host_model (.i_sys_clk(i_sys_clk), .o_req(req));
  etc_endpoint_type_config i_etc_endpoint_type_config (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_bus_reset(i_bus_reset), .i_req(req), .i_ep_index(idx),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_traffic_ep(tep), .i_pkt_done(pkt),
    .i_dma_in_done(dma), .i_in_token(tok), .i_fifo_byte_size(sz), .o_stat(o_stat),
    .o_fifo_active(fact), .o_alloc_bytes(alloc));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic miss(input logic [19:0] g, input logic [19:0] e);
    error_cnt++;
    $display("unexpected at %0t: got %h exp %h", $time, g, e);
  endtask
  task automatic chk_rd(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) miss(g, e);
  endtask
  task automatic chk_st(input logic [19:0] e);
    repeat (2) @(posedge i_sys_clk);
    #1 n_checks++;
    if ({o_stat, alloc} !== e) miss({o_stat, alloc}, e);
  endtask
  task automatic chk_fa(input logic [15:0] e);
    n_checks++;
    if (fact !== e) miss(fact, e);
  endtask
  task automatic wr(input int ep, input logic [7:0] a, input logic [15:0] d);
    if (a == ETC_ADDR_KIND_CONFIG) en_exp[ep] = d[ETC_BIT_ENABLE];
    @(posedge i_sys_clk) idx <= 4'(ep);
    i_etc_host_model.wr(a, d);
  endtask
  task automatic rd(input int ep, input logic [7:0] a, input logic [15:0] e);
    expq.push_back(e);
    @(posedge i_sys_clk) idx <= 4'(ep);
    i_etc_host_model.rd(a);
  endtask
  task automatic pulse(input int k, input int ep);
    @(posedge i_sys_clk) {pkt, dma, tok} <= 3'b100 >> k;
    tep <= 4'(ep);
    @(posedge i_sys_clk) {pkt, dma, tok} <= 3'b000;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Read answer monitor
  // ----------------------------------------
  always @(posedge i_sys_clk)
    if (o_rvalid === 1'b1)
      chk_rd(o_rdata, expq.size() ? expq.pop_front() : 16'hxxxx);
  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    miss(20'h0_0000, 20'h0_0001);
    test_done();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [3:0] ep;
    logic [15:0] d;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int e = 0; e < 16; e += 5) rd(e, ETC_ADDR_KIND_CONFIG, 16'h0000);
    wr(15, 8'h0a, 16'h001f);
    rd(15, 8'h0a, 16'h0000);
    rd(15, ETC_ADDR_KIND_CONFIG, 16'h0000);
    $display("reset and decode done");
    for (int k = 0; k < 4; k++)
    begin
      ep = 4'(rnd());
      d = {11'(rnd()), 5'h08} | 16'(k);
      wr(ep, ETC_ADDR_KIND_CONFIG, d);
      chk_st({5'b10000, 3'(4'b1000 >> k), 12'h040});
      rd(ep, ETC_ADDR_KIND_CONFIG, d & ETC_DEFINED_MASK);
    end
    chk_fa(en_exp);
    $display("kinds done");
    wr(5, ETC_ADDR_KIND_CONFIG, 16'h000a);
    pulse(0, 5);
    chk_st({5'b10010, 3'b010, 12'h040});
    wr(5, ETC_ADDR_KIND_CONFIG, 16'h000a);
    chk_st({5'b10010, 3'b010, 12'h040});
    wr(5, ETC_ADDR_KIND_CONFIG, 16'h0002);
    chk_st({5'b00010, 3'b010, 12'h000});
    chk_fa(en_exp);
    wr(5, ETC_ADDR_KIND_CONFIG, 16'h000a);
    chk_st({5'b10000, 3'b010, 12'h040});
    $display("toggle done");
    wr(6, ETC_ADDR_KIND_CONFIG, 16'h000e);
    pulse(0, 6);
    chk_st({5'b11110, 3'b010, 12'h080});
    $display("dual done");
    wr(7, ETC_ADDR_KIND_CONFIG, 16'h0009);
    pulse(1, 7);
    chk_st({5'b10001, 3'b100, 12'h040});
    pulse(2, 7);
    chk_st({5'b10000, 3'b100, 12'h040});
    wr(7, ETC_ADDR_KIND_CONFIG, 16'h0019);
    pulse(1, 7);
    chk_st({5'b10000, 3'b100, 12'h040});
    $display("empty packet done");
    @(posedge i_sys_clk) i_bus_reset <= 1'b1;
    @(posedge i_sys_clk) i_bus_reset <= 1'b0;
    en_exp = '0;
    rd(7, ETC_ADDR_KIND_CONFIG, 16'h0000);
    chk_st(20'h0_0000);
    chk_fa(en_exp);
    $display("bus reset done");
    for (int i = 0; i < 20 && expq.size() > 0; i++) @(posedge i_sys_clk);
    if (expq.size() > 0) miss(20'(expq.size()), 20'h0_0000);
    test_done();
  end
endmodule
